// ==== hw/pms_regs.svh ====
/*
 * Constants of the management-port slave: addresses, command codes,
 * reset values and timing counts.
 * Assumes nothing; included by the package and the modules.
 */
`ifndef PMS_REGS_SVH
`define PMS_REGS_SVH

// Seven-bit address group bases
`define PMS_GRP0_BASE      7'h40
`define PMS_GRP1_BASE      7'h50
`define PMS_GRP2_BASE      7'h58
`define PMS_GRP3_BASE      7'h60
// Alert response address, seven-bit form of 8'h19
`define PMS_ALERT_RESP_ADR 7'h0C
// Direction bit values
`define PMS_DIR_WRITE      1'b0
`define PMS_DIR_READ       1'b1
// Command codes
`define PMS_CMD_PAGE       8'h00
`define PMS_CMD_CLEAR      8'h03
// Page values and reset value
`define PMS_PAGE_OUT0      8'h00
`define PMS_PAGE_OUT1      8'h01
`define PMS_PAGE_BOTH      8'hFF
`define PMS_PAGE_RST       8'h00
// Link clock limits in kHz, clock in MHz
`define PMS_SCL_MIN_KHZ    50
`define PMS_SCL_MAX_KHZ    2000
`define PMS_CLK_MHZ        250
// Least clock cycles per link clock half period at the top rate
`define PMS_HALF_CYC ((`PMS_CLK_MHZ * 1000) / (2 * `PMS_SCL_MAX_KHZ))

`endif

// ==== hw/pms_pkg.sv ====
/*
 * Types of the management-port slave.
 * Assumes pms_regs.svh is reachable on the include path.
 */
package pms_pkg;
  `include "pms_regs.svh"

  // Bus phase, one-hot
  typedef enum logic [6:0] {
    PMS_IDLE = 7'h01,
    PMS_ADDR = 7'h02,
    PMS_AACK = 7'h04,
    PMS_WDAT = 7'h08,
    PMS_WACK = 7'h10,
    PMS_RDAT = 7'h20,
    PMS_RACK = 7'h40
  } pms_state_e;

  // Command write towards the regulator core
  typedef struct packed {
    logic       valid;  // One-cycle write strobe
    logic [7:0] code;   // Command code
    logic [7:0] data;   // Data byte
    logic [7:0] index;  // Byte index after the code, from 0
    logic       out0;   // Acts on output 0
    logic       out1;   // Acts on output 1
  } pms_cmd_s;

  // Whole state of the slave
  typedef struct packed {
    pms_state_e st;
    logic [7:0] shf;      // Shift register
    logic [3:0] bitc;     // Bit counter
    logic       rw;       // Direction of the transfer
    logic       alert_response_addr;      // Transfer is an alert response read
    logic       first;    // Next written byte is the code
    logic [7:0] code;     // Latched command code
    logic [7:0] idx;      // Data byte index
    logic [7:0] page;     // Page selection
    logic       alert;    // Alert pending
    logic       sda_oe;   // Drive data low
    logic       scl_d;    // Previous link clock
    logic       sda_d;    // Previous link data
    pms_cmd_s   cmd;      // Command write out
    logic       rd_req;   // Read byte request
  } pms_state_s;
endpackage : pms_pkg

// ==== hw/pms_addr_sel.sv ====
/*
 * Turns the resistor-select index into the one slave address.
 * Assumes the index is stable after reset (sampled once).
 */
`timescale 1ns/1ps
`include "pms_regs.svh"
module pms_addr_sel
  import pms_pkg::*;
(
  input  wire logic       ref_clk_i,   // Clock
  input  wire logic       reset_n_i,   // Synchronous reset, low
  input  wire logic       clk_en_i,    // Clock enable
  input  wire logic [3:0] sel_i,       // Detected resistor index
  output logic      [6:0] addr_o       // Chosen seven-bit address
);
  logic [6:0] base;   // Group base
  logic [6:0] addr_reg;
  logic       done_reg;

  // Group base and offset 0,1,4,5
  always_comb begin
    case (sel_i[3:2])
      2'h0:    base = `PMS_GRP0_BASE;
      2'h1:    base = `PMS_GRP1_BASE;
      2'h2:    base = `PMS_GRP2_BASE;
      default: base = `PMS_GRP3_BASE;
    endcase
  end

  // Catch the strap once after reset release
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      addr_reg <= 7'h00;
      done_reg <= 1'b0;
    end else if (clk_en_i && !done_reg) begin
      addr_reg <= base | {4'h0, sel_i[1], 1'b0, sel_i[0]}; // [R04] [R05]
      done_reg <= 1'b1;
    end
  end

  assign addr_o = addr_reg;
endmodule : pms_addr_sel

// ==== hw/pms_slave.sv ====
/*
 * Slave side of the two-wire management port of a dual-output
 * regulator controller: address match, command code, page, clear,
 * alert and alert response.
 * Assumes link pins synchronous to ref_clk_i, oversampled well above
 * the link rate, and an open-drain wire resolved outside.
 */
// Overview of operation
// (R01) Address bit zero: 0 write, 1 read
// (R02) Every command code 00 to FF accepted
// (R03) Page 0 output zero, page 1 output one
// (R04) Answer one address picked by select resistor
// (R05) Sixteen addresses in four groups of four
// (R06) Host sends one command per address per group
// (R07) Alert response read returns own address
// (R08) Framing follows PMBus 1.3 over SMBus 2.0
// (R09) Optional error check byte, nine bit periods
// (R10) Link clock 50 kHz to 2 MHz
// (R11) Code 00 selects page, resets to zero
// (R12) Code 03 clears faults, releases alert
`timescale 1ns/1ps
`include "pms_regs.svh"
module pms_slave
  import pms_pkg::*;
(
  input  wire logic       ref_clk_i,      // 250 MHz clock
  input  wire logic       reset_n_i,      // Synchronous reset, low
  input  wire logic       clk_en_i,       // Freezes all state when low
  input  wire logic       scl_i,          // Link clock level
  input  wire logic       sda_i,          // Link data level
  output logic            sda_o,          // Data drive value, always 0
  output logic            sda_oe_o,       // Data driven low when high
  input  wire logic [3:0] addr_sel_i,     // Resistor select index
  input  wire logic       fault_i,        // Fault event from core
  output logic            alert_output_o, // Alert, high when pending
  output logic            alert_oe_o,     // Alert pin pulled low
  output pms_cmd_s        cmd_o,          // Command write strobe
  output logic            clear_o,        // Fault clear pulse
  output logic            rd_req_o,       // Read byte wanted, pulse
  output logic      [7:0] rd_code_o,      // Code of the read
  input  wire logic [7:0] rd_data_i,      // Read byte from core
  output logic      [7:0] page_o          // Current page
);
  pms_state_s r_reg;   // Registered state
  pms_state_s r_next;  // Next state
  logic [6:0] own_addr;
  logic       scl_rise, scl_fall, start_c, stop_c;

  // Slave address from the strap
  pms_addr_sel u_addr (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .clk_en_i  (clk_en_i),
    .sel_i     (addr_sel_i),
    .addr_o    (own_addr)
  );

  // Edge and condition detectors, 62 clocks a half bit at 2 MHz [R10]
  assign scl_rise = scl_i & ~r_reg.scl_d;
  assign scl_fall = ~scl_i & r_reg.scl_d;
  assign start_c  = scl_i & r_reg.scl_d & r_reg.sda_d & ~sda_i;
  assign stop_c   = scl_i & r_reg.scl_d & ~r_reg.sda_d & sda_i;

  // Next state
  always_comb begin
    r_next        = r_reg;
    r_next.scl_d  = scl_i;
    r_next.sda_d  = sda_i;
    r_next.cmd.valid = 1'b0;
    r_next.rd_req = 1'b0;
    // Fault event sets alert; set wins over clear below
    if (start_c) begin                     // Start or repeated start
      r_next.st     = PMS_ADDR;
      r_next.bitc   = 4'h0;
      r_next.sda_oe = 1'b0;
    end else if (stop_c) begin             // Stop ends frame [R08]
      r_next.st     = PMS_IDLE;
      r_next.sda_oe = 1'b0;
      r_next.first  = 1'b1;
    end else begin
      case (r_reg.st)
        PMS_IDLE: begin
          r_next.sda_oe = 1'b0;
        end
        PMS_ADDR: begin
          if (scl_rise) begin
            r_next.shf  = {r_reg.shf[6:0], sda_i};
            r_next.bitc = r_reg.bitc + 4'h1;
          end else if (scl_fall && r_reg.bitc == 4'h8) begin
            r_next.rw  = r_reg.shf[0];     // [R01]
            r_next.alert_response_addr = (r_reg.shf[7:1] == `PMS_ALERT_RESP_ADR)
                         && r_reg.shf[0] && r_reg.alert; // [R07]
            if (r_reg.shf[7:1] == own_addr || r_next.alert_response_addr) begin // [R04]
              r_next.st     = PMS_AACK;
              r_next.sda_oe = 1'b1;
              // A write restarts the code; a read keeps it
              if (r_reg.shf[0] == `PMS_DIR_WRITE)
                r_next.first = 1'b1;
            end else begin
              r_next.st = PMS_IDLE;        // Not ours
            end
          end
        end
        PMS_AACK: begin
          if (scl_fall) begin
            r_next.bitc = 4'h0;
            if (r_reg.rw == `PMS_DIR_READ) begin // [R01]
              r_next.st = PMS_RDAT;
              // Own address with read bit on alert response [R07]
              r_next.shf = r_reg.alert_response_addr ? {own_addr, 1'b1} : rd_data_i;
              r_next.sda_oe = r_reg.alert_response_addr ? ~own_addr[6] : ~rd_data_i[7];
              r_next.idx = 8'h00;
            end else begin
              r_next.st     = PMS_WDAT;
              r_next.sda_oe = 1'b0;
            end
          end
        end
        PMS_WDAT: begin
          if (scl_rise) begin
            r_next.shf  = {r_reg.shf[6:0], sda_i};
            r_next.bitc = r_reg.bitc + 4'h1;
          end else if (scl_fall && r_reg.bitc == 4'h8) begin
            r_next.st     = PMS_WACK;
            r_next.sda_oe = 1'b1;
            if (r_reg.first) begin         // Any code 00..FF [R02]
              r_next.code  = r_reg.shf;
              r_next.first = 1'b0;
              r_next.idx   = 8'h00;
              r_next.rd_req = 1'b1;        // Prefetch for a read
              if (r_reg.shf == `PMS_CMD_CLEAR)
                r_next.alert = 1'b0;       // [R12]
            end else begin
              // Later bytes, a trailing check byte included [R09]
              r_next.cmd.valid = 1'b1;
              r_next.cmd.code  = r_reg.code;
              r_next.cmd.data  = r_reg.shf;
              r_next.cmd.index = r_reg.idx;
              r_next.cmd.out0  = r_reg.page != `PMS_PAGE_OUT1; // [R03]
              r_next.cmd.out1  = r_reg.page != `PMS_PAGE_OUT0; // [R03]
              r_next.idx       = r_reg.idx + 8'h01;
              if (r_reg.code == `PMS_CMD_PAGE && r_reg.idx == 8'h00)
                r_next.page = r_reg.shf;   // [R11]
            end
          end
        end
        PMS_WACK: begin
          if (scl_fall) begin
            r_next.st     = PMS_WDAT;
            r_next.sda_oe = 1'b0;
            r_next.bitc   = 4'h0;
          end
        end
        PMS_RDAT: begin
          if (scl_rise) begin
            r_next.bitc = r_reg.bitc + 4'h1;
          end else if (scl_fall) begin
            if (r_reg.bitc == 4'h8) begin
              r_next.st     = PMS_RACK;
              r_next.sda_oe = 1'b0;        // Master acknowledges
            end else begin
              r_next.shf    = {r_reg.shf[6:0], 1'b0};
              r_next.sda_oe = ~r_reg.shf[6];
            end
          end
        end
        PMS_RACK: begin
          if (scl_rise) begin
            if (sda_i) begin
              r_next.st = PMS_IDLE;        // Not acknowledged, done
            end else begin
              r_next.idx    = r_reg.idx + 8'h01;
              r_next.rd_req = ~r_reg.alert_response_addr;
            end
          end else if (scl_fall && r_reg.st == PMS_RACK) begin
            r_next.st     = PMS_RDAT;
            r_next.bitc   = 4'h0;
            r_next.shf    = rd_data_i;
            r_next.sda_oe = ~rd_data_i[7];
          end
        end
        default: begin
          r_next.st = PMS_IDLE;
        end
      endcase
    end
    if (fault_i)
      r_next.alert = 1'b1;                 // Set wins over clear
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      r_reg        <= '0;
      r_reg.st     <= PMS_IDLE;
      r_reg.page   <= `PMS_PAGE_RST;       // [R11]
      r_reg.first  <= 1'b1;
      r_reg.scl_d  <= 1'b1;
      r_reg.sda_d  <= 1'b1;
    end else if (clk_en_i) begin
      r_reg <= r_next;
    end
  end

  // Outputs
  assign sda_o          = 1'b0;
  assign sda_oe_o       = r_reg.sda_oe;
  assign alert_output_o = r_reg.alert;
  assign alert_oe_o     = r_reg.alert;
  assign cmd_o          = r_reg.cmd;
  // One pulse as the clear code is taken, with the alert drop [R12]
  assign clear_o        = r_reg.rd_req && r_reg.st == PMS_WACK &&
                          r_reg.code == `PMS_CMD_CLEAR;
  assign rd_req_o       = r_reg.rd_req;
  assign rd_code_o      = r_reg.code;
  assign page_o         = r_reg.page;
endmodule : pms_slave

// ==== test/pms_slave_sva.sv ====
/* Port checker of the management-port slave.
   Assumes one clock and a synchronous low reset. */
`timescale 1ns/1ps
module pms_slave_sva
  import pms_pkg::*;
(
  input wire logic       ref_clk_i,
  input wire logic       reset_n_i,
  input wire logic       clk_en_i,
  input wire logic       scl_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic       fault_i,
  input wire logic       alert_output_o,
  input wire logic       alert_oe_o,
  input wire pms_cmd_s   cmd_o,
  input wire logic       clear_o,
  input wire logic       rd_req_o,
  input wire logic [7:0] rd_code_o,
  input wire logic [7:0] page_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  sda_low_a: assert property (sda_o == 1'b0)
    else $error("data drive not low");
  oe_steady_a: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
    else $error("data drive moved with clock high");
  alert_pin_a: assert property (alert_oe_o == alert_output_o)
    else $error("alert pin and flag differ");
  fault_set_a: assert property (fault_i && clk_en_i |=> alert_output_o)
    else $error("fault did not raise alert");
  page_upd_a: assert property ($changed(page_o) |-> cmd_o.valid &&
    cmd_o.code == 8'h00 && cmd_o.index == 8'h00 && cmd_o.data == page_o)
    else $error("page moved without page write");
  out_map_a: assert property (cmd_o.valid && cmd_o.code != 8'h00 |->
    cmd_o.out0 == (page_o != 8'h01) && cmd_o.out1 == (page_o != 8'h00))
    else $error("output select wrong for page");
  cmd_once_a: assert property (cmd_o.valid |=> !cmd_o.valid)
    else $error("command strobe too long");
  code_tie_a: assert property (cmd_o.valid |-> cmd_o.code == rd_code_o)
    else $error("command code differs from latched code");
  alert_clr_a: assert property ($fell(alert_output_o) |-> clear_o &&
    rd_code_o == 8'h03)
    else $error("alert fell without clear");
  cover property (cmd_o.valid);
  cover property (rd_req_o);
  cover property ($fell(alert_output_o));
endmodule : pms_slave_sva

bind pms_slave pms_slave_sva i_sva (.ref_clk_i(ref_clk_i),
  .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .scl_i(scl_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .fault_i(fault_i), .alert_output_o(alert_output_o),
  .alert_oe_o(alert_oe_o), .cmd_o(cmd_o), .clear_o(clear_o),
  .rd_req_o(rd_req_o),
  .rd_code_o(rd_code_o), .page_o(page_o));

// ==== test/pms_host_model.sv ====
/* Bus master model of the system host, driving at the falling edge.
   Assumes a pulled-up data wire resolved by the bench. */
`timescale 1ns/1ps
module pms_host_model (
  input  wire logic ref_clk_i,  // Bench clock
  input  wire logic sda_i,      // Resolved data wire
  output logic      scl_o,      // Link clock, high when idle
  output logic      sda_o       // Data drive, 1 releases
);
  localparam int HALF = 64;     // 128 clocks a bit, under 2 MHz
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic hw(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : hw
  // Start or repeated start: data falls while clock high
  task automatic start();
    sda_o = 1'b1;
    hw(HALF);
    scl_o = 1'b1;
    hw(HALF);
    sda_o = 1'b0;
    hw(HALF);
    scl_o = 1'b0;
  endtask : start
  // Stop: data rises while clock high
  task automatic stop();
    hw(HALF / 2);
    sda_o = 1'b0;
    hw(HALF);
    scl_o = 1'b1;
    hw(HALF);
    sda_o = 1'b1;
    hw(HALF);
  endtask : stop
  // Nine bit periods, MSB first, no error check byte sent
  task automatic xbyte(input logic [7:0] d, input logic last,
                       output logic [7:0] r, output logic ack);
    logic [8:0] o;
    o = {d, last};
    for (int i = 8; i >= 0; i--) begin
      hw(HALF / 2);
      sda_o = o[i];
      hw(HALF / 2);
      scl_o = 1'b1;
      hw(HALF);
      if (i > 0) r[i-1] = sda_i;
      else ack = !sda_i;
      scl_o = 1'b0;
    end
  endtask : xbyte
endmodule : pms_host_model

// ==== test/pms_slave_bench.sv ====
/* Self-checking bench of the management-port slave.
   Assumes the host model and the checker are compiled alongside. */
`timescale 1ns/1ps
module pms_slave_bench;
  import pms_pkg::*;
  logic       ref_clk_i = 1'b0, reset_n_i = 1'b0, fault_i = 1'b0;
  logic [3:0] sel = 4'h0;                // Address strap
  logic       scl, hsda, sda_w, sda_dv;  // Link wires
  logic       sda_oe, alert, alert_oe, clear, rd_req;
  logic [7:0] rd_code, page, r;
  logic [6:0] own;                       // Expected own address
  logic       ack;
  logic       en = 1'b1;                 // Clock enable
  pms_cmd_s   cmd, last;                 // Last command strobe seen
  int         errors = 0, checked = 0, n_rd = 0, n_clr = 0;
  always #2 ref_clk_i = ~ref_clk_i;
  // Open-drain wire with pull-up
  assign sda_w = hsda & (sda_oe ? sda_dv : 1'b1);
  pms_host_model i_host (.ref_clk_i(ref_clk_i), .sda_i(sda_w),
    .scl_o(scl), .sda_o(hsda));
  pms_slave i_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .clk_en_i(en), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_dv),
    .sda_oe_o(sda_oe), .addr_sel_i(sel), .fault_i(fault_i),
    .alert_output_o(alert), .alert_oe_o(alert_oe), .cmd_o(cmd),
    .clear_o(clear), .rd_req_o(rd_req), .rd_code_o(rd_code),
    .rd_data_i(rd_code ^ 8'hA5), .page_o(page));
  // Core side: records strobes
  always @(posedge ref_clk_i) begin
    if (cmd.valid === 1'b1) last <= cmd;
    if (rd_req === 1'b1) n_rd <= n_rd + 1;
    if (clear === 1'b1) n_clr <= n_clr + 1;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    if (errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  task automatic sendb(input logic [7:0] d, input logic exp);
    i_host.xbyte(d, 1'b1, r, ack);
    check(ack, exp);
  endtask : sendb
  // One command to one address per frame, never grouped
  task automatic wr(input logic [7:0] code, input logic [7:0] d);
    i_host.start();
    sendb({own, 1'b0}, 1'b1);
    sendb(code, 1'b1);
    sendb(d, 1'b1);
    i_host.stop();
  endtask : wr
  // Every strap value answers on its own address and refuses one other address
  task automatic t_addr();
    logic [6:0] grp [4] = '{7'h40, 7'h50, 7'h58, 7'h60};
    for (int s = 0; s < 16; s++) begin
      reset_n_i = 1'b0;
      sel = 4'(s);
      own = grp[sel[3:2]] + {4'h0, sel[1], 1'b0, sel[0]};
      repeat (8) @(negedge ref_clk_i);
      reset_n_i = 1'b1;
      repeat (4) @(negedge ref_clk_i);
      i_host.start();
      sendb({own, 1'b0}, 1'b1);
      i_host.start();
      sendb({own ^ (s[0] ? 7'h04 : 7'h02), 1'b0}, 1'b0);
      i_host.stop();
    end
  endtask : t_addr
  // Page writes steer later codes to the outputs
  task automatic t_page();
    logic [7:0] pg [3] = '{8'h01, 8'hFF, 8'h00};
    logic [7:0] cd [3] = '{8'hFF, 8'h80, 8'h7E};
    check(page, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, pg[i]);
      check(page, pg[i]);
      wr(cd[i], 8'h3C);
      check(last, {1'b1, cd[i], 16'h3C00, pg[i] != 1, pg[i] != 0});
    end
  endtask : t_page
  // Code, repeated start, read back one byte
  task automatic t_read();
    int n0;
    n0 = n_rd;
    i_host.start();
    sendb({own, 1'b0}, 1'b1);
    sendb(8'h8B, 1'b1);
    i_host.start();
    sendb({own, 1'b1}, 1'b1);
    i_host.xbyte(8'hFF, 1'b1, r, ack);
    i_host.stop();
    check(r, 8'h8B ^ 8'hA5);
    check(n_rd > n0, 1'b1);
  endtask : t_read
  // Alert response refused, answered, then cleared
  task automatic t_alert();
    i_host.start();
    sendb({7'h0C, 1'b1}, 1'b0);
    i_host.stop();
    en = 1'b0;
    fault_i = 1'b1;
    @(negedge ref_clk_i);
    fault_i = 1'b0;
    en = 1'b1;
    @(negedge ref_clk_i);
    check(alert, 1'b0);
    fault_i = 1'b1;
    @(negedge ref_clk_i);
    fault_i = 1'b0;
    @(negedge ref_clk_i);
    check({alert, alert_oe}, 2'b11);
    i_host.start();
    sendb({7'h0C, 1'b1}, 1'b1);
    i_host.xbyte(8'hFF, 1'b1, r, ack);
    i_host.stop();
    check(r, {own, 1'b1});
    i_host.start();
    sendb({own, 1'b0}, 1'b1);
    sendb(8'h03, 1'b1);
    i_host.stop();
    check({alert, alert_oe}, 2'b00);
    check(n_clr, 1);
  endtask : t_alert
  initial begin
    t_addr();
    t_page();
    t_read();
    t_alert();
    finish_test();
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge ref_clk_i);
    errors++;
    finish_test();
  end
endmodule : pms_slave_bench
